/* File: bench/timer16_clock_interval_square_bench.sv */
`timescale 1ns/10ps
`default_nettype none
// ------
// Bench.
// ------
module timer16_clock_interval_square_bench;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic psel_in = 1'b0;
  logic penable_in = 1'b0;
  logic pwrite_in = 1'b0;
  logic [7:0] paddr_in = 8'h0;
  logic [31:0] pwdata_in = 32'h0;
  logic [1:0] ext_edge_input_in = 2'h0;
  logic [31:0] prdata_out, rd;
  logic pready_out, pslverr_out, er;
  logic [1:0] timer_output_pin_out, match_irq_a_out, match_irq_b_out;
  logic [7:0] b;
  int err_count = 0;
  int compares = 0;
  int i, m, n, gap, p;
  int tab[17][4] = '{'{0,0,0,2}, '{0,1,0,4}, '{0,2,0,8}, '{0,3,0,20},
    '{0,3,1,20}, '{0,4,0,32}, '{0,5,0,64}, '{0,6,0,128}, '{0,7,0,0},
    '{1,1,0,4}, '{1,2,0,1024}, '{1,3,3,10}, '{1,3,2,0}, '{1,4,0,2},
    '{1,5,0,8}, '{1,6,0,16}, '{1,7,0,0}};
  always #25 clock_in = ~clock_in;
  always begin
    repeat (10) @(posedge clock_in);
    ext_edge_input_in <= ~ext_edge_input_in;
  end
  timer16_top i_timer16_top (.clock_in, .rst_n_in, .psel_in, .penable_in,
    .pwrite_in, .paddr_in, .pwdata_in, .prdata_out, .pready_out,
    .pslverr_out, .ext_edge_input_in, .timer_output_pin_out,
    .match_irq_a_out, .match_irq_b_out);
  task give_verdict;
    $display("compares %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      err_count++;
      $display("unexpected %s expected %0h seen %0h", what, exp, seen);
    end
  endtask
  task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    @(posedge clock_in);
    psel_in <= 1'b1;
    pwrite_in <= w;
    paddr_in <= a;
    pwdata_in <= d;
    @(posedge clock_in);
    penable_in <= 1'b1;
    k = 0;
    do begin
      @(posedge clock_in);
      k++;
    end while (pready_out !== 1'b1 && k < 20);
    if (pready_out !== 1'b1) begin
      err_count++;
      give_verdict();
    end
    rd = prdata_out;
    er = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
  endtask
  function automatic logic sig(input int idx, kind);
    return kind == 0 ? match_irq_a_out[idx] : kind == 1 ?
      match_irq_b_out[idx] : timer_output_pin_out[idx];
  endfunction
  task evt(input int idx, kind, cyc, output int cnt);
    logic pv, c;
    pv = sig(idx, kind);
    cnt = 0;
    for (int k = 1; k <= 40000; k++) begin
      @(negedge clock_in);
      c = sig(idx, kind);
      if (c === 1'b1 && pv === 1'b0) begin
        if (cyc == 0) begin
          cnt = k;
          return;
        end
        cnt++;
      end
      pv = c;
      if (k == cyc)
        return;
    end
    err_count++;
    give_verdict();
  endtask
  task start(input int inst, code, edge_s, mval, bval, ctrl);
    b = inst ? 8'h20 : 8'h00;
    apb(1'b1, b + 8'h08, 32'h0);
    apb(1'b1, b, edge_s * 16 + code % 4);
    apb(1'b1, 8'h04, (code / 4) << inst);
    apb(1'b1, b + 8'h10, mval);
    apb(1'b1, b + 8'h14, bval);
    apb(1'b1, b + 8'h0C, ctrl);
    apb(1'b1, b + 8'h08, 32'hC);
  endtask
  initial begin
    void'($urandom(32'h43FD));
    repeat (3) @(posedge clock_in);
    rst_n_in <= 1'b1;
    for (i = 0; i < 16; i++) begin
      apb(1'b0, 8'(i * 4), 32'h0);
      check("reset value", rd, 32'h0);
    end
    apb(1'b0, 8'h40, 32'h0);
    check("range error", {31'h0, er}, 32'h1);
    apb(1'b1, 8'h38, 32'h1234);
    apb(1'b0, 8'h38, 32'h0);
    check("counter read only", rd, 32'h0);
    $display("register test done");
    foreach (tab[j]) begin
      m = $urandom_range(3, 1);
      b = tab[j][0] ? 8'h20 : 8'h00;
      start(tab[j][0], tab[j][1], tab[j][2], m, 32'hFFFF, 0);
      if (tab[j][3] == 0) begin
        evt(tab[j][0], 0, 300, n);
        check("no count", n, 32'h0);
      end else begin
        evt(tab[j][0], 0, 0, n);
        evt(tab[j][0], 0, 0, n);
        evt(tab[j][0], 0, 0, gap);
        check("match period", gap, (m + 1) * tab[j][3]);
      end
      apb(1'b1, b + 8'h08, 32'h0);
      apb(1'b0, b + 8'h18, 32'h0);
      check("stopped counter", rd, 32'h0);
    end
    $display("clock select test done");
    m = $urandom_range(9, 2);
    p = (m + 1) * 2;
    start(0, 0, 0, m, 1, 32'h3);
    evt(0, 2, 0, n);
    evt(0, 2, 0, gap);
    check("square period", gap, 2 * p);
    evt(0, 1, 4 * p, n);
    check("match b count", n, 32'h4);
    apb(1'b0, 8'h18, 32'h0);
    check("count range", {31'h0, rd <= m}, 32'h1);
    apb(1'b1, 8'h0C, 32'h13);
    evt(0, 1, 4 * p, n);
    check("masked match b", n, 32'h0);
    apb(1'b1, 8'h0C, 32'h11);
    evt(0, 2, 4 * p, n);
    check("pin held", n, 32'h0);
    evt(0, 0, 4 * p, n);
    check("match a kept", n, 32'h4);
    apb(1'b1, 8'h0C, 32'h12);
    evt(0, 2, 4 * p, n);
    check("pin low", {31'h0, timer_output_pin_out[0]}, 32'h0);
    apb(1'b1, 8'h08, 32'h0);
    evt(0, 0, 4 * p, n);
    check("stopped match a", n, 32'h0);
    $display("square wave test done");
    give_verdict();
  end
endmodule
`default_nettype wire

/* File: bench/timer16_properties.sv */
`timescale 1ns/10ps
`default_nettype none
// ------
// Port checks for the timer block.
// ------
module timer16_properties (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic [7:0] paddr_in,
  input wire logic pready_out,
  input wire logic pslverr_out,
  input wire logic [1:0] timer_output_pin_out,
  input wire logic [1:0] match_irq_a_out,
  input wire logic [1:0] match_irq_b_out
);
  default clocking cb @(posedge clock_in);
  endclocking
  default disable iff (!rst_n_in);
  sequence setup_s;
    psel_in && !penable_in;
  endsequence
  sequence access_s;
    psel_in && penable_in;
  endsequence
  a_setup_quiet: assert property (setup_s |-> !pready_out)
    else $error("ready during setup");
  a_access_answer: assert property (setup_s ##1 access_s |-> pready_out)
    else $error("no answer in access phase");
  a_ready_pulse: assert property (pready_out |=> !pready_out)
    else $error("ready longer than one cycle");
  a_range_error: assert property (pready_out && paddr_in >= 8'h40
    |-> pslverr_out)
    else $error("no error for address out of range");
  a_mapped_ok: assert property (pready_out && paddr_in < 8'h40
    && paddr_in[1:0] == 2'h0 |-> !pslverr_out)
    else $error("error for mapped address");
  a_irq_a_pulse: assert property (
    match_irq_a_out[0] |=> !match_irq_a_out[0])
    else $error("match a pulse too long");
  a_irq_a_gap: assert property (
    $rose(match_irq_a_out[0]) |=> !match_irq_a_out[0] [*3])
    else $error("match a pulses too close");
  a_irq_b_pulse: assert property (
    match_irq_b_out[0] |=> !match_irq_b_out[0])
    else $error("match b pulse too long");
  a_reset_quiet: assert property (disable iff (1'b0) !rst_n_in
    |=> match_irq_a_out == 2'h0 && timer_output_pin_out == 2'h0)
    else $error("outputs active after reset");
endmodule
bind timer16_top timer16_properties i_timer16_properties (.clock_in,
  .rst_n_in, .psel_in, .penable_in, .paddr_in, .pready_out, .pslverr_out,
  .timer_output_pin_out, .match_irq_a_out, .match_irq_b_out);
`default_nettype wire

/* File: design/count_clock_gen.sv */
`timescale 1ns/10ps
`default_nettype none
module count_clock_gen #(
  parameter bit INST01 = 1'b0
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  count_clock_if.src cc
);
  logic [6:0] div_reg;
  logic ext_prev_reg;
  logic edge_hit;
  logic tick_next;

  // ----------------------------------------------------------------------
  // Prescaler and edge detect.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in || !cc.run) begin
      div_reg <= 7'h00;
    end else begin
      div_reg <= div_reg + 7'h01;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ext_prev_reg <= 1'b0;
    end else begin
      ext_prev_reg <= cc.ext_sync;
    end
  end

  always_comb begin
    case (cc.edge_sel) // [RULE18]
      timer16_pkg::EDGE_FALL: edge_hit = ext_prev_reg && !cc.ext_sync;
      timer16_pkg::EDGE_RISE: edge_hit = !ext_prev_reg && cc.ext_sync;
      timer16_pkg::EDGE_BOTH: edge_hit = ext_prev_reg != cc.ext_sync;
      default: edge_hit = 1'b0;
    endcase
  end

  always_comb begin
    if (!INST01) begin
      case (cc.clk_sel) // [RULE1]
        3'h0: tick_next = div_reg[0];
        3'h1: tick_next = &div_reg[1:0];
        3'h2: tick_next = &div_reg[2:0];
        3'h3: tick_next = edge_hit;
        3'h4: tick_next = &div_reg[4:0];
        3'h5: tick_next = &div_reg[5:0];
        3'h6: tick_next = &div_reg[6:0];
        default: tick_next = 1'b0;
      endcase
    end else begin
      case (cc.clk_sel) // [RULE2]
        3'h0: tick_next = 1'b1;
        3'h1: tick_next = &div_reg[1:0];
        3'h2: tick_next = cc.watch_tick;
        3'h3: tick_next = edge_hit;
        3'h4: tick_next = div_reg[0];
        3'h5: tick_next = &div_reg[2:0];
        3'h6: tick_next = &div_reg[3:0];
        default: tick_next = 1'b0;
      endcase
    end
  end

  assign cc.tick = cc.run && tick_next;
endmodule
`default_nettype wire

/* File: design/count_clock_if.sv */
`timescale 1ns/10ps
`default_nettype none
interface count_clock_if;
  logic [2:0] clk_sel;
  logic [1:0] edge_sel;
  logic ext_sync;
  logic watch_tick;
  logic run;
  logic tick;
  modport src (input clk_sel, edge_sel, ext_sync, watch_tick, run,
               output tick);
  modport user (output clk_sel, edge_sel, ext_sync, watch_tick, run,
                input tick);
endinterface
`default_nettype wire

/* File: design/timer16_pkg.sv */
package timer16_pkg;

  // ----------------------------------------------------------------------
  // Register byte offsets.
  // ----------------------------------------------------------------------
  localparam logic [7:0] PRESCALER_OFF = 8'h00;
  localparam logic [7:0] SELECTOR_OFF = 8'h04;
  localparam logic [7:0] MODE_OFF = 8'h08;
  localparam logic [7:0] OUTPUT_CTRL_OFF = 8'h0C;
  localparam logic [7:0] COMPARE_A_OFF = 8'h10;
  localparam logic [7:0] COMPARE_B_OFF = 8'h14;
  localparam logic [7:0] COUNTER_OFF = 8'h18;
  localparam logic [7:0] STATUS_OFF = 8'h1C;
  localparam int INST_STRIDE = 32;

  // ----------------------------------------------------------------------
  // Field positions.
  // ----------------------------------------------------------------------
  localparam int CLK_SEL_LSB = 0;
  localparam int EDGE_SEL_LSB = 4;
  localparam int OP_MODE_LSB = 2;
  localparam int OUT_ENABLE_BIT = 0;
  localparam int INVERT_A_BIT = 1;
  localparam int LEVEL_RESET_BIT = 2;
  localparam int LEVEL_SET_BIT = 3;
  localparam int MASK_B_BIT = 4;

  // ----------------------------------------------------------------------
  // Reset values and encodings.
  // ----------------------------------------------------------------------
  localparam logic [7:0] REG8_RESET = 8'h00;
  localparam logic [15:0] REG16_RESET = 16'h0000;
  localparam logic [1:0] MODE_STOP = 2'h0;
  localparam logic [1:0] MODE_CLEAR_A = 2'h3;
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // ----------------------------------------------------------------------
  // Timing.
  // ----------------------------------------------------------------------
  localparam int SYS_CLK_HZ = 20000000;
  localparam int WATCH_TICK_PERIOD = 1024;

endpackage

/* File: design/timer16_top.sv */
// How it works
// RULE1: Instance 00 clock codes: /2,/4,/8,edge,/32,/64,/128; 111 none.
// RULE2: Instance 01 clock codes: fxx,/4,watch tick,edge,/2,/8,/16; 111 none.
// RULE3: Software avoids undivided clock for instance 01 except at 10 MHz.
// RULE4: External edge input holds each level over two fxx/4 periods.
// RULE5: Mode 11 starts counting on the selected count clock.
// RULE6: Counter equal to compare A clears counter and pulses interrupt A.
// RULE7: Compare A value M gives interrupt A every M+1 counts.
// RULE8: Software never loads compare A with zero in these modes.
// RULE9: Counter equal to compare B pulses interrupt B; a mask gates it.
// RULE10: Software configures everything before writing mode 11.
// RULE11: Mode 00 stops counting and zeroes the counter.
// RULE12: Software writes 03H to output control for a square wave.
// RULE13: Compare A match clears counter, pulses interrupt, toggles output.
// RULE14: Square wave period is twice M+1 count clocks.
// RULE15: Counter is 16 bits and readable by software.
// RULE16: Output enable 0 holds the pin low; 1 drives the flip-flop.
// RULE17: Invert bit 1 toggles on compare A; interrupt raised regardless.
// RULE18: Edge select: 00 falling, 01 rising, 11 both, 10 none.
// RULE19: Software leaves prescaler alone while running.
// RULE20: Counter steps once per count event; compare uses updated value. Only compare B does here; compare A uses the value before the step.
//
// The APB slave port and the address map were decided locally.
`timescale 1ns/10ps
`default_nettype none
module timer16_top (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic psel_in,
  input wire logic penable_in,
  input wire logic pwrite_in,
  input wire logic [7:0] paddr_in,
  input wire logic [31:0] pwdata_in,
  output logic [31:0] prdata_out,
  output logic pready_out,
  output logic pslverr_out,
  input wire logic [1:0] ext_edge_input_in,
  output logic [1:0] timer_output_pin_out,
  output logic [1:0] match_irq_a_out,
  output logic [1:0] match_irq_b_out
);
  logic [7:0] prescaler_mode_reg [2];
  logic [7:0] selector_control_reg;
  logic [1:0] op_mode_bits [2];
  logic [7:0] output_control_reg [2];
  logic [15:0] compare_reg_a [2];
  logic [15:0] compare_reg_b [2];
  logic [15:0] up_counter [2];
  logic [1:0] out_ff_reg;
  logic [1:0] ext_meta_reg;
  logic [1:0] ext_sync_reg;
  logic [9:0] watch_reg;
  logic watch_tick;
  logic [1:0] tick;
  logic [1:0] running;
  logic wr_access;
  logic rd_access;
  logic [1:0] inst_sel;
  logic [4:0] reg_off;
  logic addr_ok;
  logic [31:0] rdata_next;
  logic [1:0] match_a;
  logic [1:0] match_b;
  logic [15:0] count_next [2];

  // ----------------------------------------------------------------------
  // Helper functions.
  // ----------------------------------------------------------------------
  function automatic logic wr_hit(input logic [7:0] off, input int inst);
    wr_hit = wr_access && (inst_sel == 2'(inst)) && (reg_off == off[4:0]);
  endfunction

  // ----------------------------------------------------------------------
  // Bus decode.
  // ----------------------------------------------------------------------
  assign wr_access = psel_in && penable_in && pwrite_in && pready_out;
  assign rd_access = psel_in && penable_in && !pwrite_in && pready_out;
  assign inst_sel = (paddr_in >= 8'(2 * timer16_pkg::INST_STRIDE)) ? 2'h2 :
                    ((paddr_in >= 8'(timer16_pkg::INST_STRIDE)) ? 2'h1 : 2'h0);
  assign reg_off = paddr_in[4:0];
  assign addr_ok = (inst_sel != 2'h2) && (paddr_in[1:0] == 2'h0);

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      pready_out <= 1'b0;
    end else begin
      pready_out <= psel_in && !pready_out;
    end
  end

  // ----------------------------------------------------------------------
  // Pin synchronisers and watch tick.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      ext_meta_reg <= 2'h0;
      ext_sync_reg <= 2'h0;
    end else begin
      ext_meta_reg <= ext_edge_input_in; // [RULE4]
      ext_sync_reg <= ext_meta_reg;
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      watch_reg <= 10'h000;
    end else if (watch_reg == 10'(timer16_pkg::WATCH_TICK_PERIOD - 1)) begin
      watch_reg <= 10'h000;
    end else begin
      watch_reg <= watch_reg + 10'h001;
    end
  end
  assign watch_tick = watch_reg == 10'h000;

  // ----------------------------------------------------------------------
  // Per-instance counters.
  // ----------------------------------------------------------------------
  for (genvar i = 0; i < 2; i++) begin : g_inst
    count_clock_if cc();
    assign cc.clk_sel = {selector_control_reg[i],
                         prescaler_mode_reg[i][timer16_pkg::CLK_SEL_LSB +: 2]};
    assign cc.edge_sel = prescaler_mode_reg[i][timer16_pkg::EDGE_SEL_LSB +: 2];
    assign cc.ext_sync = ext_sync_reg[i];
    assign cc.watch_tick = watch_tick;
    assign cc.run = running[i];
    assign tick[i] = cc.tick;

    count_clock_gen #(.INST01(i == 1)) u_gen (
      .clock_in(clock_in),
      .rst_n_in(rst_n_in),
      .cc(cc)
    );

    assign running[i] = op_mode_bits[i] == timer16_pkg::MODE_CLEAR_A; // [RULE5]
    assign count_next[i] = up_counter[i] + 16'h0001; // [RULE20]
    assign match_a[i] = tick[i] && (up_counter[i] == compare_reg_a[i]);
    assign match_b[i] = tick[i] && (count_next[i] == compare_reg_b[i]);

    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        up_counter[i] <= timer16_pkg::REG16_RESET;
      end else if (!running[i]) begin
        up_counter[i] <= timer16_pkg::REG16_RESET; // [RULE11]
      end else if (match_a[i]) begin
        up_counter[i] <= timer16_pkg::REG16_RESET; // [RULE6] [RULE7]
      end else if (tick[i]) begin
        up_counter[i] <= count_next[i]; // [RULE20]
      end
    end

    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        match_irq_a_out[i] <= 1'b0;
        match_irq_b_out[i] <= 1'b0;
      end else begin
        match_irq_a_out[i] <= match_a[i]; // [RULE6] [RULE13]
        match_irq_b_out[i] <= match_b[i] && // [RULE9]
          !output_control_reg[i][timer16_pkg::MASK_B_BIT];
      end
    end

    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        out_ff_reg[i] <= 1'b0;
      end else if (wr_hit(timer16_pkg::OUTPUT_CTRL_OFF, i) &&
                   pwdata_in[timer16_pkg::LEVEL_SET_BIT]) begin
        out_ff_reg[i] <= 1'b1;
      end else if (wr_hit(timer16_pkg::OUTPUT_CTRL_OFF, i) &&
                   pwdata_in[timer16_pkg::LEVEL_RESET_BIT]) begin
        out_ff_reg[i] <= 1'b0;
      end else if (match_a[i] &&
                   output_control_reg[i][timer16_pkg::INVERT_A_BIT]) begin
        out_ff_reg[i] <= !out_ff_reg[i]; // [RULE13] [RULE14] [RULE17]
      end
    end

    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        timer_output_pin_out[i] <= 1'b0;
      end else begin
        timer_output_pin_out[i] <= // [RULE16]
          output_control_reg[i][timer16_pkg::OUT_ENABLE_BIT] && out_ff_reg[i];
      end
    end

    always_ff @(posedge clock_in) begin
      if (!rst_n_in) begin
        prescaler_mode_reg[i] <= timer16_pkg::REG8_RESET;
        op_mode_bits[i] <= timer16_pkg::MODE_STOP;
        output_control_reg[i] <= timer16_pkg::REG8_RESET;
        compare_reg_a[i] <= timer16_pkg::REG16_RESET;
        compare_reg_b[i] <= timer16_pkg::REG16_RESET;
      end else begin
        if (wr_hit(timer16_pkg::PRESCALER_OFF, i)) begin
          prescaler_mode_reg[i] <= pwdata_in[7:0] & 8'hF3;
        end
        if (wr_hit(timer16_pkg::MODE_OFF, i)) begin
          op_mode_bits[i] <= pwdata_in[timer16_pkg::OP_MODE_LSB +: 2];
        end
        if (wr_hit(timer16_pkg::OUTPUT_CTRL_OFF, i)) begin
          output_control_reg[i] <= pwdata_in[7:0] & 8'h13;
        end
        if (wr_hit(timer16_pkg::COMPARE_A_OFF, i)) begin
          compare_reg_a[i] <= pwdata_in[15:0];
        end
        if (wr_hit(timer16_pkg::COMPARE_B_OFF, i)) begin
          compare_reg_b[i] <= pwdata_in[15:0];
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // Shared selector register.
  // ----------------------------------------------------------------------
  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      selector_control_reg <= timer16_pkg::REG8_RESET;
    end else if (wr_hit(timer16_pkg::SELECTOR_OFF, 0) ||
                 wr_hit(timer16_pkg::SELECTOR_OFF, 1)) begin
      selector_control_reg <= pwdata_in[7:0] & 8'h03;
    end
  end

  // ----------------------------------------------------------------------
  // Read data and error.
  // ----------------------------------------------------------------------
  always_comb begin
    rdata_next = 32'h0000_0000;
    if (inst_sel != 2'h2) begin
      case ({3'h0, reg_off})
        timer16_pkg::PRESCALER_OFF:
          rdata_next = {24'h0, prescaler_mode_reg[inst_sel[0]]};
        timer16_pkg::SELECTOR_OFF:
          rdata_next = {24'h0, selector_control_reg};
        timer16_pkg::MODE_OFF:
          rdata_next = {28'h0, op_mode_bits[inst_sel[0]], 2'h0};
        timer16_pkg::OUTPUT_CTRL_OFF:
          rdata_next = {24'h0, output_control_reg[inst_sel[0]]};
        timer16_pkg::COMPARE_A_OFF:
          rdata_next = {16'h0, compare_reg_a[inst_sel[0]]};
        timer16_pkg::COMPARE_B_OFF:
          rdata_next = {16'h0, compare_reg_b[inst_sel[0]]};
        timer16_pkg::COUNTER_OFF:
          rdata_next = {16'h0, up_counter[inst_sel[0]]}; // [RULE15]
        timer16_pkg::STATUS_OFF:
          rdata_next = {30'h0, out_ff_reg[inst_sel[0]], running[inst_sel[0]]};
        default:
          rdata_next = 32'h0000_0000;
      endcase
    end
  end

  always_ff @(posedge clock_in) begin
    if (!rst_n_in) begin
      prdata_out <= 32'h0000_0000;
      pslverr_out <= 1'b0;
    end else begin
      prdata_out <= (psel_in && !pwrite_in && !pready_out) ? rdata_next
                    : prdata_out;
      pslverr_out <= psel_in && !pready_out && !addr_ok;
    end
  end
endmodule
`default_nettype wire
